// ---- design/flash_read_pkg.sv ----
package flash_read_pkg;
   // ==========================================
   // opcodes seen on the serial link
   localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
   localparam logic [7:0] OP_DUAL_IO = 8'hbb;
   localparam logic [7:0] OP_QUAD_IO = 8'heb;
   localparam logic [7:0] OP_SET_WRAP = 8'h77;
   localparam logic [7:0] OP_SET_PARAM = 8'hc0;
   localparam logic [7:0] OP_RESET_EN = 8'h66;
   localparam logic [7:0] OP_RESET = 8'h99;
   // ==========================================
   // lane encodings and phase lengths in clocks
   localparam logic [1:0] LANES_1 = 2'h0;
   localparam logic [1:0] LANES_2 = 2'h1;
   localparam logic [1:0] LANES_4 = 2'h2;
   localparam logic [5:0] CMD_CLKS_SPI = 6'h08;
   localparam logic [5:0] CMD_CLKS_QPI = 6'h02;
   localparam logic [5:0] ADDR_CLKS_1 = 6'h18;
   localparam logic [5:0] ADDR_CLKS_2 = 6'h0c;
   localparam logic [5:0] ADDR_CLKS_4 = 6'h06;
   localparam logic [5:0] BYTE_CLKS_1 = 6'h08;
   localparam logic [5:0] BYTE_CLKS_2 = 6'h04;
   localparam logic [5:0] BYTE_CLKS_4 = 6'h02;
   localparam logic [5:0] SPI_FAST_DUMMY = 6'h08;
   localparam logic [5:0] SPI_QUAD_IO_DUMMY = 6'h04;
   // four-line dummy totals per dummy_count_field, mode clocks included
   localparam logic [5:0] QPI_DUMMY_0 = 6'h04;
   localparam logic [5:0] QPI_DUMMY_1 = 6'h04;
   localparam logic [5:0] QPI_DUMMY_2 = 6'h06;
   localparam logic [5:0] QPI_DUMMY_3 = 6'h08;
   localparam logic [5:0] CNT_ONE = 6'h01;
   localparam logic [5:0] CNT_ZERO = 6'h00;
   // ==========================================
   // field positions and reset values
   localparam int SKIP_LO = 4;
   localparam logic [1:0] SKIP_CODE = 2'b10;
   localparam int WRAP_LO = 4;
   localparam int DUMMY_LO = 4;
   localparam logic [2:0] WRAP_RESET = 3'b001;
   localparam logic [1:0] DUMMY_RESET = 2'b00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] WRAP_MASK_8 = 8'h07;
   localparam logic [7:0] WRAP_MASK_16 = 8'h0f;
   localparam logic [7:0] WRAP_MASK_32 = 8'h1f;
   localparam logic [7:0] WRAP_MASK_64 = 8'h3f;
   // ==========================================
   // sequencer states
   typedef enum logic [6:0] {
      ST_CMD = 7'h01,
      ST_ADDR = 7'h02,
      ST_MODE = 7'h04,
      ST_DUMMY = 7'h08,
      ST_DATA = 7'h10,
      ST_CFG = 7'h20,
      ST_IGNORE = 7'h40
   } seq_state_t;
endpackage

// ---- design/multi_io_flash_read_wrap.sv ----
// Behaviour
// - 3BH: address, dummy byte, dual data out
// - address increments after every data byte
// - 6BH: address, dummy byte, quad data out
// - quad reads need status_bit_nine set, except EBH in four-line mode
// - BBH: address and mode byte on two lines
// - skip code 10 drops next opcode
// - other skip codes need full opcode
// - reset sequence clears continuous_mode_byte
// - EBH: address, mode, four dummies, quad
// - four-line EBH dummies follow dummy_count_field
// - four-line mode clocks count as dummies
// - four-line EBH reads ignore wrap
// - wrap_disable_bit zero enables wrapping
// - wrap_length_field picks 8/16/32/64 bytes
// - wrapped output stays in aligned section
// - wrap_setting_bits kept for later reads
// - data driven on falling serial edge
// - nibble high bit on data_line_3
`timescale 1ns/100ps
module multi_io_flash_read_wrap (
   // core clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // status bits from the core
   input wire logic status_bit_nine_in,
   input wire logic four_line_command_mode_in,
   // serial link
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe_out,
   // array read port, serial clock domain
   output logic [23:0] array_addr_out,
   input wire logic [7:0] array_data_in,
   // status toward the core
   output logic frame_active_out,
   output logic continuous_mode_out,
   output logic wrap_enabled_out
);
   // ==========================================
   // serial domain registers
   flash_read_pkg::seq_state_t state_r, state_nxt; // frame sequencer
   logic [5:0] cnt_r, cnt_nxt; // clock count inside a phase
   logic [31:0] sh_r, sh_nxt; // input shift register
   logic [7:0] cmd_r, cmd_nxt; // opcode of this frame
   logic [23:0] addr_r, addr_nxt; // read address
   logic [7:0] mode_byte_r, mode_byte_nxt; // continuous_mode_byte
   logic skip_r, skip_nxt; // opcode skip armed
   logic [7:0] last_op_r, last_op_nxt; // opcode repeated on skip
   logic [2:0] wrap_r, wrap_nxt; // wrap_setting_bits {len, disable}
   logic [1:0] dummy_field_r, dummy_field_nxt; // dummy_count_field
   logic rst_armed_r, rst_armed_nxt; // reset enable seen
   logic [1:0] stat_meta_r; // first sync stage, qe and four-line
   logic [1:0] stat_r; // second sync stage
   logic [7:0] out_sh_r; // output byte shifter, falling edge
   logic [3:0] io_out_r; // driven line levels
   logic [3:0] io_oe_r; // line enables
   // ==========================================
   // core domain sync flops
   logic [2:0] core_meta_r; // first stage
   logic [2:0] core_sync_r; // second stage
   localparam int SKIP_HI = flash_read_pkg::SKIP_LO + 1;
   localparam int WRAP_HI = flash_read_pkg::WRAP_LO + 2;
   localparam int DUMMY_HI = flash_read_pkg::DUMMY_LO + 1;

   // ==========================================
   // decode wires
   wire frame_rst = cs_n_in | sys_rst_in; // frame logic dies with chip select
   wire qe_s = stat_r[0]; // quad_lines_allowed_bit, synced
   wire qpi_s = stat_r[1]; // four_line_command_mode, synced
   wire st_cmd = (state_r == flash_read_pkg::ST_CMD);
   wire skip_start = st_cmd & skip_r; // first bits are the address
   wire [7:0] op_w = skip_start ? last_op_r : cmd_r; // opcode in force
   wire op_quad_io = (op_w == flash_read_pkg::OP_QUAD_IO);
   wire op_dual_io = (op_w == flash_read_pkg::OP_DUAL_IO);
   wire op_dual_out = (op_w == flash_read_pkg::OP_DUAL_OUT);
   wire op_wrap_cfg = (op_w == flash_read_pkg::OP_SET_WRAP);
   wire op_param = (op_w == flash_read_pkg::OP_SET_PARAM);
   wire [7:0] new_op = sh_nxt[7:0]; // opcode as it completes

   // lanes for address, mode, dummy and configuration phases
   wire [1:0] addr_lanes = (op_quad_io | qpi_s) ? flash_read_pkg::LANES_4 :
                           op_dual_io ? flash_read_pkg::LANES_2 :
                           flash_read_pkg::LANES_1;
   wire [1:0] data_lanes = op_dual_out | op_dual_io ? flash_read_pkg::LANES_2 :
                           flash_read_pkg::LANES_4;
   wire [1:0] cmd_lanes = qpi_s ? flash_read_pkg::LANES_4 : flash_read_pkg::LANES_1;
   wire [1:0] in_lanes = (st_cmd & ~skip_r) ? cmd_lanes : addr_lanes;

   // phase lengths in clocks
   wire [5:0] addr_clks = (addr_lanes == flash_read_pkg::LANES_4) ? flash_read_pkg::ADDR_CLKS_4 :
                          (addr_lanes == flash_read_pkg::LANES_2) ? flash_read_pkg::ADDR_CLKS_2 :
                          flash_read_pkg::ADDR_CLKS_1;
   wire [5:0] byte_clks_in = (addr_lanes == flash_read_pkg::LANES_4) ?
                             flash_read_pkg::BYTE_CLKS_4 :
                             (addr_lanes == flash_read_pkg::LANES_2) ?
                             flash_read_pkg::BYTE_CLKS_2 : flash_read_pkg::BYTE_CLKS_1;
   wire [5:0] byte_clks_out = (data_lanes == flash_read_pkg::LANES_4) ?
                              flash_read_pkg::BYTE_CLKS_4 : flash_read_pkg::BYTE_CLKS_2;
   wire [5:0] cmd_clks = qpi_s ? flash_read_pkg::CMD_CLKS_QPI : flash_read_pkg::CMD_CLKS_SPI;
   // four-line total includes the mode byte clocks
   wire [5:0] qpi_total = (dummy_field_r == 2'b00) ? flash_read_pkg::QPI_DUMMY_0 :
                          (dummy_field_r == 2'b01) ? flash_read_pkg::QPI_DUMMY_1 :
                          (dummy_field_r == 2'b10) ? flash_read_pkg::QPI_DUMMY_2 :
                          flash_read_pkg::QPI_DUMMY_3;
   wire [5:0] qpi_dummy = qpi_total - flash_read_pkg::BYTE_CLKS_4;
   wire [5:0] dummy_clks = ~op_quad_io ? flash_read_pkg::SPI_FAST_DUMMY :
                           qpi_s ? qpi_dummy : flash_read_pkg::SPI_QUAD_IO_DUMMY;

   // length of the phase now running
   logic [5:0] phase_len;
   always_comb begin
      // one length per state, idle states never end
      case (state_r)
         flash_read_pkg::ST_CMD: phase_len = skip_r ? addr_clks : cmd_clks;
         flash_read_pkg::ST_ADDR: phase_len = addr_clks;
         flash_read_pkg::ST_MODE: phase_len = byte_clks_in;
         flash_read_pkg::ST_DUMMY: phase_len = dummy_clks;
         flash_read_pkg::ST_DATA: phase_len = byte_clks_out;
         flash_read_pkg::ST_CFG: phase_len = byte_clks_in;
         default: phase_len = flash_read_pkg::CNT_ZERO;
      endcase
   end
   wire phase_last = (phase_len != flash_read_pkg::CNT_ZERO) &&
                     (cnt_r == phase_len - flash_read_pkg::CNT_ONE);

   // input shift, highest bit of a nibble on data_line_3
   always_comb begin
      case (in_lanes)
         flash_read_pkg::LANES_4: sh_nxt = {sh_r[27:0], io_in[3:0]};
         flash_read_pkg::LANES_2: sh_nxt = {sh_r[29:0], io_in[1:0]};
         default: sh_nxt = {sh_r[30:0], io_in[0]};
      endcase
   end

   // address advance with optional wrap inside the page
   wire wrap_on = ~wrap_r[0] & op_quad_io & ~qpi_s;
   wire [7:0] wrap_mask = (wrap_r[2:1] == 2'b00) ? flash_read_pkg::WRAP_MASK_8 :
                          (wrap_r[2:1] == 2'b01) ? flash_read_pkg::WRAP_MASK_16 :
                          (wrap_r[2:1] == 2'b10) ? flash_read_pkg::WRAP_MASK_32 :
                          flash_read_pkg::WRAP_MASK_64;
   wire [23:0] addr_inc = addr_r + 24'h000001;
   wire [7:0] addr_wrap = (addr_r[7:0] & ~wrap_mask) | (addr_inc[7:0] & wrap_mask);
   wire [23:0] addr_adv = wrap_on ? {addr_r[23:8], addr_wrap} : addr_inc;

   // opcode gate: commands not served here are ignored to frame end
   logic ok_cmd;
   always_comb begin
      // quad reads refused while the quad bit is clear, except EBH in four-line mode
      case (new_op)
         flash_read_pkg::OP_DUAL_OUT: ok_cmd = ~qpi_s;
         flash_read_pkg::OP_DUAL_IO: ok_cmd = ~qpi_s;
         flash_read_pkg::OP_QUAD_OUT: ok_cmd = ~qpi_s & qe_s;
         flash_read_pkg::OP_QUAD_IO: ok_cmd = qpi_s | qe_s;
         flash_read_pkg::OP_SET_WRAP: ok_cmd = ~qpi_s;
         default: ok_cmd = 1'b0;
      endcase
   end

   // ==========================================
   // next state of the frame sequencer
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = phase_last ? flash_read_pkg::CNT_ZERO : cnt_r + flash_read_pkg::CNT_ONE;
      cmd_nxt = cmd_r;
      addr_nxt = addr_r;
      case (state_r)
         flash_read_pkg::ST_CMD: begin
            if (phase_last && skip_r) begin
               // continuous read: these bits were the address
               cmd_nxt = last_op_r;
               addr_nxt = sh_nxt[23:0];
               state_nxt = flash_read_pkg::ST_MODE;
            end else if (phase_last) begin
               cmd_nxt = new_op;
               if (new_op == flash_read_pkg::OP_SET_PARAM) begin
                  state_nxt = flash_read_pkg::ST_CFG;
               end else if (ok_cmd) begin
                  state_nxt = flash_read_pkg::ST_ADDR;
               end else begin
                  state_nxt = flash_read_pkg::ST_IGNORE;
               end
            end
         end
         flash_read_pkg::ST_ADDR: begin
            if (phase_last) begin
               // any start address accepted
               addr_nxt = sh_nxt[23:0];
               if (op_wrap_cfg) begin
                  state_nxt = flash_read_pkg::ST_CFG;
               end else if (op_quad_io | op_dual_io) begin
                  state_nxt = flash_read_pkg::ST_MODE;
               end else begin
                  state_nxt = flash_read_pkg::ST_DUMMY;
               end
            end
         end
         flash_read_pkg::ST_MODE: begin
            if (phase_last) begin
               // dual io has no dummies after the mode byte
               state_nxt = op_quad_io ? flash_read_pkg::ST_DUMMY : flash_read_pkg::ST_DATA;
            end
         end
         flash_read_pkg::ST_DUMMY: begin
            if (phase_last) begin
               state_nxt = flash_read_pkg::ST_DATA;
            end
         end
         flash_read_pkg::ST_DATA: begin
            if (phase_last) begin
               addr_nxt = addr_adv;
            end
         end
         flash_read_pkg::ST_CFG: begin
            if (phase_last) begin
               state_nxt = flash_read_pkg::ST_IGNORE;
            end
         end
         default: begin
            // ignore until chip select rises
            cnt_nxt = flash_read_pkg::CNT_ZERO;
         end
      endcase
   end

   // ==========================================
   // next value of settings that outlive a frame
   always_comb begin
      mode_byte_nxt = mode_byte_r;
      skip_nxt = skip_r;
      last_op_nxt = last_op_r;
      wrap_nxt = wrap_r;
      dummy_field_nxt = dummy_field_r;
      rst_armed_nxt = rst_armed_r;
      if ((state_r == flash_read_pkg::ST_MODE) && phase_last) begin
         // capture the mode byte and decide on skipping
         mode_byte_nxt = sh_nxt[7:0];
         skip_nxt = (sh_nxt[SKIP_HI:flash_read_pkg::SKIP_LO] ==
                     flash_read_pkg::SKIP_CODE);
         last_op_nxt = op_w;
      end
      if ((state_r == flash_read_pkg::ST_CFG) && phase_last && op_wrap_cfg) begin
         // kept until the next wrap command
         wrap_nxt = sh_nxt[WRAP_HI:flash_read_pkg::WRAP_LO];
      end
      if ((state_r == flash_read_pkg::ST_CFG) && phase_last && op_param) begin
         dummy_field_nxt = sh_nxt[DUMMY_HI:flash_read_pkg::DUMMY_LO];
      end
      if (st_cmd && ~skip_r && phase_last) begin
         // reset needs the enable opcode in the frame before
         rst_armed_nxt = (new_op == flash_read_pkg::OP_RESET_EN);
         if ((new_op == flash_read_pkg::OP_RESET) && rst_armed_r) begin
            mode_byte_nxt = flash_read_pkg::MODE_RESET;
            skip_nxt = 1'b0;
         end
      end
   end

   // ==========================================
   // frame state, cleared whenever chip select is high
   always_ff @(posedge sck_in or posedge frame_rst) begin
      if (frame_rst) begin
         state_r <= flash_read_pkg::ST_CMD;
         cnt_r <= flash_read_pkg::CNT_ZERO;
         sh_r <= 32'h00000000;
         cmd_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         cmd_r <= cmd_nxt;
      end
   end

   // read address, held across frames so the array port is stable
   always_ff @(posedge sck_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         addr_r <= 24'h000000;
      end else begin
         addr_r <= addr_nxt;
      end
   end

   // settings only system reset clears; wrap survives chip select
   always_ff @(posedge sck_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mode_byte_r <= flash_read_pkg::MODE_RESET;
         skip_r <= 1'b0;
         last_op_r <= flash_read_pkg::OP_QUAD_IO;
         wrap_r <= flash_read_pkg::WRAP_RESET;
         dummy_field_r <= flash_read_pkg::DUMMY_RESET;
         rst_armed_r <= 1'b0;
      end else begin
         mode_byte_r <= mode_byte_nxt;
         skip_r <= skip_nxt;
         last_op_r <= last_op_nxt;
         wrap_r <= wrap_nxt;
         dummy_field_r <= dummy_field_nxt;
         rst_armed_r <= rst_armed_nxt;
      end
   end

   // status bits into the serial domain; the link clock stops between
   // frames, so a change is seen only after two edges of a frame
   always_ff @(posedge sck_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         stat_meta_r <= 2'b00;
         stat_r <= 2'b00;
      end else begin
         stat_meta_r <= {four_line_command_mode_in, status_bit_nine_in};
         stat_r <= stat_meta_r;
      end
   end

   // ==========================================
   // output side on the falling edge
   wire byte_start = (cnt_r == flash_read_pkg::CNT_ZERO);
   wire [7:0] out_byte = byte_start ? array_data_in : out_sh_r;
   wire in_data = (state_r == flash_read_pkg::ST_DATA);
   wire quad_out = (data_lanes == flash_read_pkg::LANES_4);
   wire [3:0] drive_bits = quad_out ? out_byte[7:4] : {2'b00, out_byte[7:6]};
   wire [3:0] drive_en = quad_out ? 4'hf : 4'h3;
   wire [7:0] out_shift = quad_out ? {out_byte[3:0], 4'h0} : {out_byte[5:0], 2'b00};

   // data changes on the falling edge so the host samples it rising
   always_ff @(negedge sck_in or posedge frame_rst) begin
      if (frame_rst) begin
         out_sh_r <= 8'h00;
         io_out_r <= 4'h0;
         io_oe_r <= 4'h0;
      end else if (in_data) begin
         out_sh_r <= out_shift;
         io_out_r <= drive_bits;
         io_oe_r <= drive_en;
      end else begin
         out_sh_r <= 8'h00;
         io_out_r <= 4'h0;
         io_oe_r <= 4'h0;
      end
   end

   assign io_out = io_out_r;
   assign io_oe_out = io_oe_r;
   assign array_addr_out = addr_r;

   // ==========================================
   // status levels into the core domain
   always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         core_meta_r <= 3'b000;
         core_sync_r <= 3'b000;
      end else begin
         core_meta_r <= {~wrap_r[0], skip_r, ~cs_n_in};
         core_sync_r <= core_meta_r;
      end
   end

   assign frame_active_out = core_sync_r[0];
   assign continuous_mode_out = core_sync_r[1];
   assign wrap_enabled_out = core_sync_r[2];
endmodule

// ---- sim/flash_read_chk.sv ----
`timescale 1ns/100ps
// ==========================================
// port checks for the flash read block
module flash_read_chk (
   // clocks and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic sck_in,
   // watched ports
   input wire logic status_bit_nine_in,
   input wire logic cs_n_in,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe_out,
   input wire logic [23:0] array_addr_out,
   input wire logic frame_active_out,
   input wire logic continuous_mode_out,
   input wire logic wrap_enabled_out
);
   logic [3:0] io_rise_r; // level seen at each rising sck edge
   // capture at the rise so a change there shows at the next fall
   always_ff @(posedge sck_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         io_rise_r <= 4'h0;
      end else begin
         io_rise_r <= io_out;
      end
   end
   property p_oe_release;
      @(posedge core_clk_in) disable iff (sys_rst_in) cs_n_in |-> io_oe_out == 4'h0;
   endproperty
   a_oe_release: assert property (p_oe_release) else $error("driving while deselected");
   property p_frame_on;
      @(posedge core_clk_in) disable iff (sys_rst_in) !cs_n_in [*5] |-> frame_active_out;
   endproperty
   a_frame_on: assert property (p_frame_on) else $error("frame flag missing");
   property p_fall_launch;
      @(negedge sck_in) disable iff (sys_rst_in || cs_n_in)
         io_oe_out != 4'h0 |-> (io_out & io_oe_out) == (io_rise_r & io_oe_out);
   endproperty
   a_fall_launch: assert property (p_fall_launch) else $error("data moved on rise");
   property p_lane_set;
      @(posedge core_clk_in) disable iff (sys_rst_in) io_oe_out inside {4'h0, 4'h3, 4'hf};
   endproperty
   a_lane_set: assert property (p_lane_set) else $error("odd lane enables");
   property p_quad_gate;
      @(posedge sck_in) disable iff (sys_rst_in || cs_n_in)
         !status_bit_nine_in [*4] |-> io_oe_out != 4'hf;
   endproperty
   a_quad_gate: assert property (p_quad_gate) else $error("quad drive without bit");
   property p_wrap_hold;
      @(posedge core_clk_in) disable iff (sys_rst_in) cs_n_in [*6] |-> $stable(wrap_enabled_out);
   endproperty
   a_wrap_hold: assert property (p_wrap_hold) else $error("wrap moved idle");
   property p_skip_hold;
      @(posedge core_clk_in) disable iff (sys_rst_in) cs_n_in [*6] |-> $stable(continuous_mode_out);
   endproperty
   a_skip_hold: assert property (p_skip_hold) else $error("skip moved idle");
   property p_addr_step;
      @(posedge sck_in) disable iff (sys_rst_in || cs_n_in)
         (io_oe_out != 4'h0 && array_addr_out != $past(array_addr_out))
         |-> array_addr_out[2:0] == 3'($past(array_addr_out[2:0]) + 3'h1);
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("address step not one");
   c_quad: cover property (@(posedge core_clk_in) io_oe_out == 4'hf);
   c_dual: cover property (@(posedge core_clk_in) io_oe_out == 4'h3);
   c_wrap: cover property (@(posedge core_clk_in) $rose(wrap_enabled_out));
endmodule
bind multi_io_flash_read_wrap flash_read_chk chk_u (
   .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .sck_in(sck_in),
   .status_bit_nine_in(status_bit_nine_in), .cs_n_in(cs_n_in), .io_out(io_out),
   .io_oe_out(io_oe_out), .array_addr_out(array_addr_out), .frame_active_out(frame_active_out),
   .continuous_mode_out(continuous_mode_out), .wrap_enabled_out(wrap_enabled_out)
);

// ---- sim/flash_host_model.sv ----
`timescale 1ns/100ps
// ==========================================
// host serial controller: frames, clocks, shared lines
module flash_host_model (
   // link toward the device
   output logic sck_out,
   output logic cs_n_out,
   output logic [3:0] io_line_out,
   input wire logic [3:0] dev_io_in,
   input wire logic [3:0] dev_oe_in
);
   logic [3:0] h_d; // last value the host drove
   logic [3:0] h_oe; // host lane enables
   logic drive_seen; // device drove in this frame
   // undriven lanes show the inverse of the last value, never a stale copy
   assign io_line_out = (dev_oe_in & dev_io_in) | (~dev_oe_in & h_oe & h_d)
      | (~dev_oe_in & ~h_oe & ~h_d);
   initial begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      h_d = 4'h0;
      h_oe = 4'h0;
      drive_seen = 1'b0;
   end
   // one clock: lanes change after the fall, sampled at the rise
   task automatic cyc(input logic [3:0] d, input logic [3:0] oe, output logic [3:0] s);
      h_d = d;
      h_oe = oe;
      #40;
      s = io_line_out;
      drive_seen = drive_seen | (|dev_oe_in);
      sck_out = 1'b1;
      #40;
      sck_out = 1'b0;
   endtask
   // msb first, w lanes a clock, top bit on the highest lane
   task automatic send(input int w, input int n, input logic [31:0] v);
      logic [3:0] s;
      logic [3:0] m;
      m = 4'((1 << w) - 1);
      for (int k = n - 1; k >= 0; k--) begin
         cyc(4'(v >> (k * w)) & m, m, s);
      end
   endtask
   // collect n clocks of w lanes, first clock in the high bits
   task automatic recv(input int w, input int n, output logic [31:0] v);
      logic [3:0] s;
      v = 32'h0;
      for (int k = 0; k < n; k++) begin
         cyc(h_d, 4'h0, s);
         v = (v << w) | 32'(s & 4'((1 << w) - 1));
      end
   endtask
   task automatic open_frame();
      cs_n_out = 1'b0;
      drive_seen = 1'b0;
      #40;
   endtask
   // clock stays still; long gap lets the core flags settle
   task automatic close_frame();
      h_oe = 4'h0;
      cs_n_out = 1'b1;
      #400;
   endtask
endmodule

// ---- sim/multi_io_flash_read_wrap_tb.sv ----
`timescale 1ns/100ps
// ==========================================
// read path bench; array holds a pattern of its address
module multi_io_flash_read_wrap_tb;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic status_bit_nine_in = 1'b0;
   logic four_line_command_mode_in = 1'b0;
   logic sck;
   logic cs_n;
   logic [3:0] io_line;
   logic [3:0] io_out;
   logic [3:0] io_oe_out;
   logic [23:0] array_addr_out;
   logic [7:0] array_data_in;
   logic frame_active_out;
   logic continuous_mode_out;
   logic wrap_enabled_out;
   logic [31:0] got;
   int fails = 0;
   int check_count = 0;
   always #25 core_clk_in = ~core_clk_in;
   assign array_data_in = array_addr_out[7:0] ^ 8'h5a;
   multi_io_flash_read_wrap dut_u (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .status_bit_nine_in(status_bit_nine_in),
      .four_line_command_mode_in(four_line_command_mode_in), .sck_in(sck), .cs_n_in(cs_n),
      .io_in(io_line), .io_out(io_out), .io_oe_out(io_oe_out), .array_addr_out(array_addr_out),
      .array_data_in(array_data_in), .frame_active_out(frame_active_out),
      .continuous_mode_out(continuous_mode_out), .wrap_enabled_out(wrap_enabled_out));
   flash_host_model host_u (.sck_out(sck), .cs_n_out(cs_n), .io_line_out(io_line),
      .dev_io_in(io_out), .dev_oe_in(io_oe_out));
   // ==========================================
   // helpers
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // bytes from a, low bits inside msk wrap within their section
   function automatic logic [31:0] exp_rd(input logic [23:0] a, input int n,
      input logic [23:0] msk);
      logic [31:0] v;
      logic [23:0] b;
      v = 32'h0;
      for (int i = 0; i < n; i++) begin
         b = (a & ~msk) | ((a + 24'(i)) & msk);
         v = (v << 8) | 32'(b[7:0] ^ 8'h5a);
      end
      return v;
   endfunction
   // read frame; oc of zero leaves out the opcode
   task automatic rd(input int cw, input int oc, input logic [7:0] op, input int aw,
      input logic [23:0] a, input int mc, input logic [7:0] mb, input int dc, input int rw,
      input int rn);
      host_u.open_frame();
      host_u.send(cw, oc, 32'(op));
      host_u.send(aw, 24 / aw, 32'(a));
      host_u.send(aw, mc, 32'(mb));
      host_u.send(aw, dc, 32'h0);
      host_u.recv(rw, rn, got);
      host_u.close_frame();
   endtask
   task automatic cfg(input int w, input int n, input logic [7:0] op, input int pn,
      input logic [7:0] b);
      host_u.open_frame();
      host_u.send(w, n, 32'(op));
      host_u.send(w, pn, 32'h0);
      host_u.send(w, 8 / w, 32'(b));
      host_u.close_frame();
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      fails++;
      give_verdict();
   end
   // ==========================================
   // tests
   initial begin
      repeat (12) @(posedge core_clk_in);
      #1 sys_rst_in = 1'b0;
      rd(1, 8, flash_read_pkg::OP_QUAD_OUT, 1, 24'h000040, 8, 8'h00, 0, 4, 4);
      check("quad refused", 32'(host_u.drive_seen), 32'h0);
      @(posedge core_clk_in);
      #1 status_bit_nine_in = 1'b1;
      rd(1, 8, flash_read_pkg::OP_DUAL_OUT, 1, 24'h0012fe, 8, 8'h00, 0, 2, 12);
      check("dual out", got, exp_rd(24'h0012fe, 3, 24'hffffff));
      rd(1, 8, flash_read_pkg::OP_QUAD_OUT, 1, 24'h00aa10, 8, 8'h00, 0, 4, 6);
      check("quad out", got, exp_rd(24'h00aa10, 3, 24'hffffff));
      $display("test output reads done");
      rd(1, 8, flash_read_pkg::OP_DUAL_IO, 2, 24'h000501, 4, 8'h20, 0, 2, 8);
      check("dual io", got, exp_rd(24'h000501, 2, 24'hffffff));
      check("skip armed", 32'(continuous_mode_out), 32'h1);
      rd(1, 0, 8'h00, 2, 24'h000733, 4, 8'h00, 0, 2, 8);
      check("no opcode read", got, exp_rd(24'h000733, 2, 24'hffffff));
      check("skip cleared", 32'(continuous_mode_out), 32'h0);
      $display("test continuous done");
      for (int l = 0; l < 4; l++) begin
         cfg(1, 8, flash_read_pkg::OP_SET_WRAP, 24, 8'(l << 5));
         check("wrap on", 32'(wrap_enabled_out), 32'h1);
         rd(1, 8, flash_read_pkg::OP_QUAD_IO, 4, 24'h00347e + 24'(8 << l), 2, 8'h00, 4, 4, 8);
         check("wrap read", got, exp_rd(24'h00347e + 24'(8 << l), 4,
            24'((8 << l) - 1)));
      end
      $display("test wrap lengths done");
      @(posedge core_clk_in);
      #1 four_line_command_mode_in = 1'b1;
      cfg(4, 2, 8'h00, 0, 8'h00);
      for (int p = 0; p < 4; p++) begin
         cfg(4, 2, flash_read_pkg::OP_SET_PARAM, 0, 8'(p << 4));
         rd(4, 2, flash_read_pkg::OP_QUAD_IO, 4, 24'h0034be, 2, 8'h00, (p < 2) ? 2 : 2 * p, 4, 8);
         check("four line read", got, exp_rd(24'h0034be, 4, 24'hffffff));
      end
      $display("test four line done");
      @(posedge core_clk_in);
      #1 four_line_command_mode_in = 1'b0;
      cfg(1, 8, 8'h00, 0, 8'h00);
      cfg(1, 8, flash_read_pkg::OP_SET_WRAP, 24, 8'h10);
      check("wrap off", 32'(wrap_enabled_out), 32'h0);
      rd(1, 8, flash_read_pkg::OP_QUAD_IO, 4, 24'h003486, 2, 8'h00, 4, 4, 8);
      check("linear read", got, exp_rd(24'h003486, 4, 24'hffffff));
      $display("test wrap exit done");
      give_verdict();
   end
endmodule
